// ### tx_control_regs.svh
// Offsets, field positions, reset values and frame sizes of the transmitter control bank
`ifndef TX_CONTROL_REGS_SVH
`define TX_CONTROL_REGS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define FRAME_BITS        24
`define ADDR_MSB          3
`define DATA_LSB          4
`define DATA_MSB          19

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_RF_MAIN_DIV  4'h0
`define ADDR_RF_REF_DIV   4'h1
`define ADDR_OP_CONTROL   4'h4
`define ADDR_SETUP        4'h5
`define ADDR_BIAS_CONTROL 4'h6

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_OP_CONTROL    16'h090F
`define RST_SETUP         16'hD03F
`define RST_BIAS_CONTROL  16'h0038

// ****************************************************************
// Operational control fields
// ****************************************************************
`define OP_RF_LO_PORT     15
`define OP_RF_BOOST_LO    14
`define OP_IF_BOOST_HOLD  13
`define OP_BAND_HI        12
`define OP_BAND_LO        11
`define OP_IF_PORT        10
`define OP_IF_OSC_BAND    9
`define OP_IF_GAIN_HI     8
`define OP_IF_GAIN_LO     6
`define OP_SIDEBAND       5
`define OP_IF_LO_BUF      4
`define OP_MOD_KIND       3
`define OP_FULL_FULL_STANDBY_N_N    2
`define OP_TX_FULL_STANDBY_N_N      1
`define OP_SOFT_PD_N      0

// ****************************************************************
// Setup fields
// ****************************************************************
`define CFG_IF_LOOP_N     15
`define CFG_RF_LOOP_N     14
`define CFG_ZERO_BIAS     13
`define CFG_BB_SWING      12
`define CFG_IF_LO_DIV     11
`define CFG_EXT_OSC       10
`define CFG_IF_PUMP_HI    9
`define CFG_IF_PUMP_LO    8
`define CFG_RF_PUMP_HI    7
`define CFG_RF_PUMP_LO    6
`define CFG_IF_SENSE      5
`define CFG_RF_SENSE      4
`define CFG_IF_TURBO      3
`define CFG_RF_BOOST_HI   2
`define CFG_LOCK_SEL_HI   1
`define CFG_LOCK_SEL_LO   0

// ****************************************************************
// Bias control fields
// ****************************************************************
`define BIAS_PRESCALER    13
`define BIAS_MAX_POWER    11
`define BIAS_TEMP_HI      10
`define BIAS_TEMP_LO      9
`define BIAS_EXT_MOD      7
`define BIAS_ROLLBACK_HI  6
`define BIAS_ROLLBACK_LO  4
`define BIAS_DRV_SCALE_HI 3
`define BIAS_DRV_SCALE_LO 0

`endif

// ### tx_control_pkg.sv
// Types of the transmitter control bank
package tx_control_pkg;

  typedef struct packed {
    logic [23:0] shift;
  } link_state_t;

  typedef struct packed {
    logic        cs_meta;
    logic        cs_sync;
    logic        cs_prev;
    logic [3:0]  pin_meta;
    logic [3:0]  pin_sync;
    logic [15:0] op;
    logic [15:0] cfg;
    logic [15:0] bias;
    logic        rf_pending;
    logic        chip_active;
    logic        tx_path_on;
    logic        rf_boost_on;
    logic        if_boost_on;
    logic        lock_out;
  } sys_state_t;

endpackage

// ### tx_control_register_bank.sv
// Serially loaded control register bank of a dual-band transmitter
// What this block does
// - Frame is 24 bits, 4 unused, 16 data MSB first then 4 address, sampled rising clock.
// - Chip-select rising latches shift register into the addressed register.
// - Address 0100 operational control, 0101 setup, 0110 bias control.
// - RF boost modes: none, after reprogram until lock, always, while unlocked.
// - Op bit 15 picks low or high LO port, reset 0.
// - Op bit 14 and setup bit 2 form the RF boost mode.
// - Setup bit 3 adds IF pump current while acquiring; op bit 13 holds it.
// - Op bits 12:11 band mode FM, cellular, lower PCS, upper PCS; reset 01.
// - Op bit 10 picks IF port pair; bit 9 picks IF oscillator band.
// - Op bits 8:6 IF gain code, about 2 dB per step, reset 100.
// - Op bit 5 selects upper sideband when 1, lower when 0.
// - Op bit 4 enables IF LO buffer; setup bit 11 adds divide-by-two.
// - Op bit 3 selects quadrature modulation, 0 direct oscillator; reset 1.
// - Op bit 2 or bit 0 low powers down all, registers kept.
// - Op bit 1 low turns off transmit path, same as transmit-gate pin.
// - Setup bits 15, 14 low power down IF and RF loops; reset 1.
// - Setup bit 12 picks baseband range; bit 10 enables external oscillator.
// - Setup bits 9:8 IF pump current, bits 7:6 RF pump current.
// - Setup bits 5, 4 set IF and RF detector polarity; reset 1.
// - Setup bits 1:0 route lock pin: IF, RF, AND; 00 is test.
// - Setup bit 13 high removes upper PCS driver bias; reset 0.
// - Bias bit 13 selects higher-band prescaler when 1.
// - Bias bit 11 selects max power; bits 10:9 temperature scale.
// - Bias bit 7 routes external input straight to IF gain stage.
// - Bias bits 6:4 roll-back rate reset 011; bits 3:0 scale reset 1000.
`timescale 1ns/10ps
`include "tx_control_regs.svh"

module tx_control_register_bank (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        serial_clk,
  input  wire logic        serial_cs_n,
  input  wire logic        serial_data,
  input  wire logic        tx_gate_n_pin,
  input  wire logic        powerdown_n_pin,
  input  wire logic        if_lock_in,
  input  wire logic        rf_lock_in,
  output logic             rf_lo_port_select,
  output logic             if_boost_hold,
  output logic [1:0]       band_mode,
  output logic             if_port_select,
  output logic             if_osc_band_select,
  output logic [2:0]       if_gain_step,
  output logic             sideband_select,
  output logic             if_lo_buffer_on,
  output logic             modulation_kind,
  output logic             full_standby_n,
  output logic             tx_path_standby_n,
  output logic             soft_powerdown_n,
  output logic             if_loop_off_n,
  output logic             rf_loop_off_n,
  output logic             pcs_upper_bias_off,
  output logic             baseband_swing_sel,
  output logic             if_lo_divide_sel,
  output logic             ext_osc_input_sel,
  output logic [1:0]       if_pump_level,
  output logic [1:0]       rf_pump_level,
  output logic             if_detector_sense,
  output logic             rf_detector_sense,
  output logic [1:0]       lock_out_select,
  output logic [15:0]      bias_control_word,
  output logic             prescaler_band_sel,
  output logic             max_power_sel,
  output logic [1:0]       temp_comp_scale,
  output logic             ext_modulator_route,
  output logic [2:0]       rollback_rate,
  output logic [3:0]       driver_current_scale,
  output logic             chip_active,
  output logic             tx_path_on,
  output logic             rf_boost_on,
  output logic             if_boost_on,
  output logic             lock_out
);

  // ****************************************************************
  // Link side shift register
  // ****************************************************************
  tx_control_pkg::link_state_t link_q;
  tx_control_pkg::link_state_t link_d;

  always_comb begin
    link_d = link_q;
    if (!serial_cs_n) begin
      link_d.shift = {link_q.shift[`FRAME_BITS-2:0], serial_data};
    end
  end

  always_ff @(posedge serial_clk) begin
    link_q <= link_d;
  end

  // ****************************************************************
  // System side registers
  // ****************************************************************
  tx_control_pkg::sys_state_t st_q;
  tx_control_pkg::sys_state_t st_d;

  logic        frame_end;
  logic [3:0]  frame_addr;
  logic [15:0] frame_data;

  // Shift word is stable: the link clock idles while chip-select is high
  assign frame_end  = st_q.cs_sync & ~st_q.cs_prev;
  assign frame_addr = link_q.shift[`ADDR_MSB:0];
  assign frame_data = link_q.shift[`DATA_MSB:`DATA_LSB];

  always_comb begin
    st_d          = st_q;
    st_d.cs_meta  = serial_cs_n;
    st_d.cs_sync  = st_q.cs_meta;
    st_d.cs_prev  = st_q.cs_sync;
    st_d.pin_meta = {rf_lock_in, if_lock_in, powerdown_n_pin, tx_gate_n_pin};
    st_d.pin_sync = st_q.pin_meta;
    if (frame_end) begin
      if (frame_addr == `ADDR_OP_CONTROL) begin
        st_d.op = frame_data;
      end else if (frame_addr == `ADDR_SETUP) begin
        st_d.cfg = frame_data;
      end else if (frame_addr == `ADDR_BIAS_CONTROL) begin
        st_d.bias = frame_data;
      end
    end
    // pending boost, reprogram wins over lock
    if (frame_end && (frame_addr == `ADDR_RF_MAIN_DIV || frame_addr == `ADDR_RF_REF_DIV)) begin
      st_d.rf_pending = 1'b1;
    end else if (st_q.pin_sync[3]) begin
      st_d.rf_pending = 1'b0;
    end
    st_d.chip_active = st_q.op[`OP_FULL_FULL_STANDBY_N_N] & st_q.op[`OP_SOFT_PD_N] & st_q.pin_sync[1];
    st_d.tx_path_on = st_q.op[`OP_FULL_FULL_STANDBY_N_N] & st_q.op[`OP_SOFT_PD_N] & st_q.pin_sync[1]
                      & st_q.op[`OP_TX_FULL_STANDBY_N_N] & st_q.pin_sync[0];
    case ({st_q.op[`OP_RF_BOOST_LO], st_q.cfg[`CFG_RF_BOOST_HI]})
      2'h0:    st_d.rf_boost_on = 1'b0;
      2'h1:    st_d.rf_boost_on = st_q.rf_pending;
      2'h2:    st_d.rf_boost_on = 1'b1;
      default: st_d.rf_boost_on = ~st_q.pin_sync[3];
    endcase
    // IF boost while acquiring or held
    st_d.if_boost_on = st_q.cfg[`CFG_IF_TURBO] & (~st_q.pin_sync[2] | st_q.op[`OP_IF_BOOST_HOLD]);
    case (st_q.cfg[`CFG_LOCK_SEL_HI:`CFG_LOCK_SEL_LO])
      2'h1:    st_d.lock_out = st_q.pin_sync[2];
      2'h2:    st_d.lock_out = st_q.pin_sync[3];
      2'h3:    st_d.lock_out = st_q.pin_sync[2] & st_q.pin_sync[3];
      default: st_d.lock_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q             <= '0;
      st_q.cs_meta     <= 1'b1;
      st_q.cs_sync     <= 1'b1;
      st_q.cs_prev     <= 1'b1;
      st_q.op          <= `RST_OP_CONTROL;
      st_q.cfg         <= `RST_SETUP;
      st_q.bias        <= `RST_BIAS_CONTROL;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Field outputs
  // ****************************************************************
  // LO port
  assign rf_lo_port_select   = st_q.op[`OP_RF_LO_PORT];
  assign if_boost_hold       = st_q.op[`OP_IF_BOOST_HOLD];
  assign band_mode           = st_q.op[`OP_BAND_HI:`OP_BAND_LO];
  assign if_port_select      = st_q.op[`OP_IF_PORT];
  assign if_osc_band_select  = st_q.op[`OP_IF_OSC_BAND];
  assign if_gain_step        = st_q.op[`OP_IF_GAIN_HI:`OP_IF_GAIN_LO];
  assign sideband_select     = st_q.op[`OP_SIDEBAND];
  assign if_lo_buffer_on     = st_q.op[`OP_IF_LO_BUF];
  assign if_lo_divide_sel    = st_q.cfg[`CFG_IF_LO_DIV];
  assign modulation_kind     = st_q.op[`OP_MOD_KIND];
  assign full_standby_n      = st_q.op[`OP_FULL_FULL_STANDBY_N_N];
  assign tx_path_standby_n   = st_q.op[`OP_TX_FULL_STANDBY_N_N];
  assign soft_powerdown_n    = st_q.op[`OP_SOFT_PD_N];
  assign if_loop_off_n       = st_q.cfg[`CFG_IF_LOOP_N];
  assign rf_loop_off_n       = st_q.cfg[`CFG_RF_LOOP_N];
  assign pcs_upper_bias_off  = st_q.cfg[`CFG_ZERO_BIAS];
  assign baseband_swing_sel  = st_q.cfg[`CFG_BB_SWING];
  assign ext_osc_input_sel   = st_q.cfg[`CFG_EXT_OSC];
  assign if_pump_level       = st_q.cfg[`CFG_IF_PUMP_HI:`CFG_IF_PUMP_LO];
  assign rf_pump_level       = st_q.cfg[`CFG_RF_PUMP_HI:`CFG_RF_PUMP_LO];
  assign if_detector_sense   = st_q.cfg[`CFG_IF_SENSE];
  assign rf_detector_sense   = st_q.cfg[`CFG_RF_SENSE];
  assign lock_out_select     = st_q.cfg[`CFG_LOCK_SEL_HI:`CFG_LOCK_SEL_LO];
  assign bias_control_word   = st_q.bias;
  assign prescaler_band_sel  = st_q.bias[`BIAS_PRESCALER];
  assign max_power_sel       = st_q.bias[`BIAS_MAX_POWER];
  assign temp_comp_scale     = st_q.bias[`BIAS_TEMP_HI:`BIAS_TEMP_LO];
  assign ext_modulator_route = st_q.bias[`BIAS_EXT_MOD];
  assign rollback_rate       = st_q.bias[`BIAS_ROLLBACK_HI:`BIAS_ROLLBACK_LO];
  assign driver_current_scale = st_q.bias[`BIAS_DRV_SCALE_HI:`BIAS_DRV_SCALE_LO];
  assign chip_active         = st_q.chip_active;
  assign tx_path_on          = st_q.tx_path_on;
  assign rf_boost_on         = st_q.rf_boost_on;
  assign if_boost_on         = st_q.if_boost_on;
  assign lock_out            = st_q.lock_out;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_frame_end;
    st_q.cs_sync && !st_q.cs_prev;
  endsequence

  sequence s_op_write;
    s_frame_end ##0 (frame_addr == `ADDR_OP_CONTROL);
  endsequence

  property p_reset_values;
    @(posedge clk_sys) disable iff (1'b0)
      srst |=> (st_q.op == `RST_OP_CONTROL) && (st_q.cfg == `RST_SETUP) && (st_q.bias == `RST_BIAS_CONTROL);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_op_write;
    s_op_write |=> st_q.op == $past(frame_data);
  endproperty
  a_op_write: assert property (p_op_write) else $error("op control not loaded");

  property p_setup_only;
    s_frame_end ##0 (frame_addr == `ADDR_SETUP) |=> $stable(st_q.op) && $stable(st_q.bias);
  endproperty
  a_setup_only: assert property (p_setup_only) else $error("wrong register loaded");

  property p_hold_idle;
    !st_q.cs_sync || st_q.cs_prev |=> $stable(st_q.op) && $stable(st_q.cfg) && $stable(st_q.bias);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("register changed without frame");

  property p_power_down;
    !st_q.op[`OP_SOFT_PD_N] ##1 !st_q.op[`OP_SOFT_PD_N] |-> !chip_active && !tx_path_on;
  endproperty
  a_power_down: assert property (p_power_down) else $error("active while powered down");

  property p_tx_gate;
    !st_q.pin_sync[0] |=> !tx_path_on;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transmit path on with gate low");

  property p_boost_always;
    st_q.op[`OP_RF_BOOST_LO] && !st_q.cfg[`CFG_RF_BOOST_HI] |=> rf_boost_on;
  endproperty
  a_boost_always: assert property (p_boost_always) else $error("boost not forced on");

  property p_boost_none;
    !st_q.op[`OP_RF_BOOST_LO] && !st_q.cfg[`CFG_RF_BOOST_HI] |=> !rf_boost_on;
  endproperty
  a_boost_none: assert property (p_boost_none) else $error("boost on while disabled");

  property p_if_boost;
    st_q.cfg[`CFG_IF_TURBO] && st_q.op[`OP_IF_BOOST_HOLD] |=> if_boost_on;
  endproperty
  a_if_boost: assert property (p_if_boost) else $error("IF boost not held");

  property p_lock_and;
    st_q.cfg[`CFG_LOCK_SEL_HI:`CFG_LOCK_SEL_LO] == 2'h3 |=> lock_out == $past(st_q.pin_sync[2] & st_q.pin_sync[3]);
  endproperty
  a_lock_and: assert property (p_lock_and) else $error("lock output not AND");

endmodule

// ### tx_serial_host.sv
// Host model that drives the three-wire serial bus
`timescale 1ns/10ps

module tx_serial_host (
  output logic serial_clk,
  output logic serial_cs_n,
  output logic serial_data
);
  // ****************************************
  // Idle bus, clock stands still
  // ****************************************
  initial begin
    serial_clk  = 1'b0;
    serial_cs_n = 1'b1;
    serial_data = 1'b0;
  end

  // ****************************************
  // Frame transfer
  // ****************************************
  // 24 bits, MSB first
  task automatic send_frame(input logic [3:0] addr, input logic [15:0] data, input int gap);
    logic [23:0] frame;
    frame = {4'hF, data, addr};
    serial_cs_n = 1'b0;
    #40;
    for (int i = 23; i >= 0; i--) begin
      serial_data = frame[i];
      #62.5 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
    end
    #30 serial_cs_n = 1'b1;
    serial_data = ~serial_data;
    #(gap);
  endtask
endmodule

// ### tb_top.sv
// Testbench of the transmitter control register bank
`timescale 1ns/10ps
`include "tx_control_regs.svh"

module tb_top;
  logic        clk_sys, srst, serial_clk, serial_cs_n, serial_data;
  logic        tx_gate_n_pin, powerdown_n_pin, if_lock_in, rf_lock_in;
  logic        rf_lo_port_select, if_boost_hold, if_port_select, if_osc_band_select, sideband_select;
  logic        if_lo_buffer_on, modulation_kind, full_standby_n, tx_path_standby_n, soft_powerdown_n;
  logic        if_loop_off_n, rf_loop_off_n, pcs_upper_bias_off, baseband_swing_sel, if_lo_divide_sel;
  logic        ext_osc_input_sel, if_detector_sense, rf_detector_sense, prescaler_band_sel, max_power_sel;
  logic        ext_modulator_route, chip_active, tx_path_on, rf_boost_on, if_boost_on, lock_out, pend;
  logic [1:0]  band_mode, if_pump_level, rf_pump_level, lock_out_select, temp_comp_scale;
  logic [2:0]  if_gain_step, rollback_rate;
  logic [3:0]  driver_current_scale;
  logic [15:0] bias_control_word, exp_op, exp_cfg, exp_bias;
  int          num_errors, checks_done;
  logic [3:0]  t_addr [11] = '{4'h4, 4'h5, 4'h6, 4'h4, 4'h2, 4'h7, 4'h4, 4'h5, 4'h6, 4'hF, 4'h4};
  logic [15:0] t_data [11] = '{16'h5A5A, 16'h2A95, 16'h2EF5, 16'h8300, 16'hFFFF, 16'h0000, 16'h0B4F,
                               16'h5562, 16'h0A4A, 16'h1234, 16'h1547};
  int          t_gap  [11] = '{100, 25, 100, 100, 25, 100, 100, 100, 25, 100, 100};

  tx_control_register_bank u_tx_control_register_bank (
    .clk_sys, .srst, .serial_clk, .serial_cs_n, .serial_data, .tx_gate_n_pin, .powerdown_n_pin,
    .if_lock_in, .rf_lock_in, .rf_lo_port_select, .if_boost_hold, .band_mode, .if_port_select,
    .if_osc_band_select, .if_gain_step, .sideband_select, .if_lo_buffer_on, .modulation_kind,
    .full_standby_n, .tx_path_standby_n, .soft_powerdown_n, .if_loop_off_n, .rf_loop_off_n,
    .pcs_upper_bias_off, .baseband_swing_sel, .if_lo_divide_sel, .ext_osc_input_sel, .if_pump_level,
    .rf_pump_level, .if_detector_sense, .rf_detector_sense, .lock_out_select, .bias_control_word,
    .prescaler_band_sel, .max_power_sel, .temp_comp_scale, .ext_modulator_route, .rollback_rate,
    .driver_current_scale, .chip_active, .tx_path_on, .rf_boost_on, .if_boost_on, .lock_out
  );

  tx_serial_host u_tx_serial_host (.serial_clk, .serial_cs_n, .serial_data);

  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic send(input logic [3:0] a, input logic [15:0] d, input int g);
    u_tx_serial_host.send_frame(a, d, g);
    case (a)
      `ADDR_OP_CONTROL:                    exp_op = d;
      `ADDR_SETUP:                         exp_cfg = d;
      `ADDR_BIAS_CONTROL:                  exp_bias = d;
      `ADDR_RF_MAIN_DIV, `ADDR_RF_REF_DIV: pend = ~rf_lock_in;
      default: ;
    endcase
  endtask

  task automatic set_pins(input logic [3:0] k);
    @(negedge clk_sys);
    {powerdown_n_pin, tx_gate_n_pin, if_lock_in, rf_lock_in} = k;
    if (k[0]) pend = 1'b0;
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic check_regs();
    logic [15:0] v;
    v = {rf_lo_port_select, exp_op[14], if_boost_hold, band_mode, if_port_select, if_osc_band_select,
         if_gain_step, sideband_select, if_lo_buffer_on, modulation_kind, full_standby_n,
         tx_path_standby_n, soft_powerdown_n};
    check(v, exp_op);
    v = {if_loop_off_n, rf_loop_off_n, pcs_upper_bias_off, baseband_swing_sel, if_lo_divide_sel,
         ext_osc_input_sel, if_pump_level, rf_pump_level, if_detector_sense, rf_detector_sense,
         exp_cfg[3:2], lock_out_select};
    check(v, exp_cfg);
    v = {bias_control_word[15:14], prescaler_band_sel, bias_control_word[12], max_power_sel,
         temp_comp_scale, bias_control_word[8], ext_modulator_route, rollback_rate, driver_current_scale};
    check(v, exp_bias);
    check(bias_control_word, exp_bias);
  endtask

  task automatic check_derived();
    logic       on;
    logic       lk;
    logic [1:0] m;
    on = exp_op[2] & exp_op[0] & powerdown_n_pin;
    m = {exp_op[14], exp_cfg[2]};
    lk = exp_cfg[1] ? (rf_lock_in & (if_lock_in | ~exp_cfg[0])) : (exp_cfg[0] & if_lock_in);
    check(16'(chip_active), 16'(on));
    check(16'(tx_path_on), 16'(on & exp_op[1] & tx_gate_n_pin));
    check(16'(if_boost_on), 16'(exp_cfg[3] & (~if_lock_in | exp_op[13])));
    check(16'(lock_out), 16'(lk));
    check(16'(rf_boost_on), 16'((m == 2'h2) | ((m == 2'h3) & ~rf_lock_in) | ((m == 2'h1) & pend)));
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    srst = 1'b1;
    {powerdown_n_pin, tx_gate_n_pin, if_lock_in, rf_lock_in} = 4'hD;
    num_errors = 0;
    checks_done = 0;
    pend = 1'b0;
    exp_op = `RST_OP_CONTROL;
    exp_cfg = `RST_SETUP;
    exp_bias = `RST_BIAS_CONTROL;
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    repeat (8) @(negedge clk_sys);
    check_regs();
    check_derived();
    $display("test reset_values done");
    for (int a = 0; a < 2; a++) begin
      set_pins(4'hC);
      send(4'(a), 16'h1234, 100);
      repeat (8) @(negedge clk_sys);
      check_derived();
      set_pins(4'hD);
      check_derived();
      set_pins(4'hC);
      check_derived();
    end
    $display("test reprogram_boost done");
    for (int i = 0; i < 11; i++) begin
      send(t_addr[i], t_data[i], t_gap[i]);
      if (t_gap[i] > 30) begin
        repeat (8) @(negedge clk_sys);
        check_regs();
        check_derived();
      end
    end
    $display("test register_writes done");
    for (int j = 0; j < 4; j++) begin
      send(`ADDR_OP_CONTROL, {1'b0, j[1], j[0], 13'h090F}, 25);
      send(`ADDR_SETUP, {12'hD03, 1'b1, j[0], (j == 0) ? 2'h3 : j[1:0]}, 100);
      repeat (8) @(negedge clk_sys);
      check_regs();
      for (int k = 0; k < 16; k++) begin
        set_pins(k[3:0]);
        check_derived();
      end
    end
    $display("test modes_and_pins done");
    final_report();
  end

  initial begin
    #400000;
    num_errors++;
    final_report();
  end
endmodule
